// ---- logic/lcsc_pkg.sv ----
// Constants shared by the clock select and receive control block
package lcsc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] LCSC_ADDR_CTRL = 8'h81;
	localparam logic [7:0] LCSC_CTRL_RESET = 8'h00;
	localparam int LCSC_BIT_VIOL_OVF_SEL = 7;
	localparam int LCSC_BIT_REF_SEL_HI = 6;
	localparam int LCSC_BIT_REF_SEL_LO = 4;
	localparam int LCSC_BIT_RATE = 3;
	localparam int LCSC_BIT_MUTE = 2;
	localparam int LCSC_BIT_EXT_LOS = 1;
	localparam int LCSC_BIT_HIZ = 0;
	localparam int LCSC_UPPER_LO = 3;

	// ****************************************************************
	// Frequencies in kHz
	// ****************************************************************
	localparam logic [11:0] LCSC_KHZ_E1 = 12'h800;
	localparam logic [11:0] LCSC_KHZ_T1 = 12'h608;
	localparam logic [2:0] LCSC_REF_SEL_E1 = 3'h0;
	localparam logic [2:0] LCSC_REF_SEL_T1 = 3'h1;

	// ****************************************************************
	// Loss of signal zero counts
	// ****************************************************************
	localparam int LCSC_LOS_W = 13;
	localparam logic [12:0] LCSC_LOS_EXT_ZEROS = 13'h1000;
	localparam logic [12:0] LCSC_LOS_T1_ZEROS = 13'h00AF + 13'h004B;
	localparam logic [12:0] LCSC_LOS_E1_ZEROS = 13'h0020;

	// ****************************************************************
	// Synthesizer retune timing
	// ****************************************************************
	localparam int LCSC_CLK_PERIOD_NS = 25;
	localparam int LCSC_RETUNE_TIME_NS = 10000;
	localparam int LCSC_RETUNE_CYCLES = LCSC_RETUNE_TIME_NS / LCSC_CLK_PERIOD_NS;
	localparam int LCSC_RETUNE_W = 9;

	// Retune sequencer states
	typedef enum logic [1:0] {
		LCSC_RT_IDLE = 2'b01,
		LCSC_RT_BUSY = 2'b10
	} lcsc_rt_state_t;

endpackage

// ---- logic/lcsc_los_chan.sv ----
// One receive channel: zero counter, loss of signal flag and output muting
`timescale 1ns/10ps
module lcsc_los_chan (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Recovered line data
	input wire logic bit_valid_in,
	input wire logic bit_mark_in,
	input wire logic rx_pos_in,
	input wire logic rx_neg_in,
	// Control
	input wire logic [lcsc_pkg::LCSC_LOS_W-1:0] threshold_in,
	input wire logic mute_en_in,
	// Status and data
	output logic los_out,
	output logic rx_pos_out,
	output logic rx_neg_out
);
	import lcsc_pkg::*;

	logic [LCSC_LOS_W-1:0] zeros_q, zeros_d, zeros_inc;
	logic los_q, los_d, pos_q, pos_d, neg_q, neg_d;

	// ****************************************************************
	// Zero counting
	// ****************************************************************
	// Counter saturates so an idle line cannot wrap back under threshold
	always_comb begin
		zeros_inc = (zeros_q == {LCSC_LOS_W{1'b1}}) ? zeros_q : zeros_q + 1'b1;
		zeros_d = zeros_q;
		los_d = los_q;
		if (bit_valid_in) begin
			if (bit_mark_in) begin
				zeros_d = '0;
				los_d = 1'b0;
			end else begin
				zeros_d = zeros_inc;
				if (zeros_inc >= threshold_in) begin
					los_d = 1'b1;
				end
			end
		end
		pos_d = rx_pos_in & ~(mute_en_in & los_q);
		neg_d = rx_neg_in & ~(mute_en_in & los_q);
	end

	// Registers
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			zeros_q <= '0;
			los_q <= 1'b0;
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end else begin
			zeros_q <= zeros_d;
			los_q <= los_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
		end
	end

	assign los_out = los_q;
	assign rx_pos_out = pos_q;
	assign rx_neg_out = neg_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	chk_los_declare: assert property (
		bit_valid_in && !bit_mark_in && (zeros_inc >= threshold_in) |=> los_q)
		else $error("loss of signal not declared at threshold");
	chk_los_early: assert property (
		!los_q && bit_valid_in && !bit_mark_in && (zeros_inc < threshold_in) |=> !los_q)
		else $error("loss of signal declared too early");
	chk_mute_data: assert property (
		mute_en_in && los_q |=> !rx_pos_out && !rx_neg_out)
		else $error("data not muted during loss of signal");
	chk_unmuted_pass: assert property (
		!mute_en_in |=> rx_pos_out == $past(rx_pos_in))
		else $error("data altered while mute is off");
	cov_los_seen: cover property (bit_valid_in && !bit_mark_in ##1 los_q);
endmodule

// ---- logic/lcsc_top.sv ----
// Global clock select and receive control register with its channel logic
`timescale 1ns/10ps
module lcsc_top #(
	parameter int CHANNELS = 8,
	parameter int RETUNE_CYCLES = lcsc_pkg::LCSC_RETUNE_CYCLES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Microprocessor register port
	input wire logic [7:0] host_addr_in,
	input wire logic [7:0] host_wdata_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	output logic [7:0] host_rdata_out,
	// Per channel line events and recovered data
	input wire logic [CHANNELS-1:0] line_code_violation_in,
	input wire logic [CHANNELS-1:0] counter_overflow_in,
	input wire logic [CHANNELS-1:0] rx_bit_valid_in,
	input wire logic [CHANNELS-1:0] rx_bit_mark_in,
	input wire logic [CHANNELS-1:0] rx_pos_in,
	input wire logic [CHANNELS-1:0] rx_neg_in,
	// Per channel outputs
	output logic [CHANNELS-1:0] violation_overflow_indicator_out,
	output logic [CHANNELS-1:0] receive_loss_of_signal_out,
	output logic [CHANNELS-1:0] receive_positive_data_out,
	output logic [CHANNELS-1:0] receive_negative_violation_out,
	// Synthesizer control and in circuit test high impedance
	output logic [2:0] synth_ref_select_field_out,
	output logic master_rate_select_out,
	output logic [11:0] synth_ref_khz_out,
	output logic [11:0] synth_clock_output_khz_out,
	output logic synth_retune_busy_out,
	output logic in_circuit_test_hiz_out
);
	import lcsc_pkg::*;

	// ****************************************************************
	// Register port
	// ****************************************************************
	logic [7:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
	logic ctrl_wr;

	// Address decode is shared by read and write
	function automatic logic hits_ctrl(input logic [7:0] addr);
		return addr == LCSC_ADDR_CTRL;
	endfunction

	// Next register and read values; unmapped reads return zero
	always_comb begin
		ctrl_wr = host_wr_in && hits_ctrl(host_addr_in);
		// one write updates the whole register, both groups at once
		ctrl_d = ctrl_wr ? host_wdata_in : ctrl_q;
		rdata_d = rdata_q;
		if (host_rd_in) begin
			rdata_d = hits_ctrl(host_addr_in) ? ctrl_q : 8'h00;
		end
	end

	// Register storage
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ctrl_q <= LCSC_CTRL_RESET;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// Synthesizer selection and retune tracking
	// ****************************************************************
	logic [2:0] ref_sel;
	logic rate_sel, clk_fields_change;
	logic [11:0] ref_khz_d, ref_khz_q, out_khz_d, out_khz_q;
	lcsc_rt_state_t rt_q, rt_d;
	logic [LCSC_RETUNE_W-1:0] rt_cnt_q, rt_cnt_d;

	// Unlisted reference codes fall back to the E1 reference
	always_comb begin
		ref_sel = ctrl_d[LCSC_BIT_REF_SEL_HI:LCSC_BIT_REF_SEL_LO];
		rate_sel = ctrl_d[LCSC_BIT_RATE];
		ref_khz_d = (ref_sel == LCSC_REF_SEL_T1) ? LCSC_KHZ_T1 : LCSC_KHZ_E1;
		out_khz_d = rate_sel ? LCSC_KHZ_T1 : LCSC_KHZ_E1;
		clk_fields_change = ctrl_d[LCSC_BIT_REF_SEL_HI:LCSC_UPPER_LO]
			!= ctrl_q[LCSC_BIT_REF_SEL_HI:LCSC_UPPER_LO];
	end

	// Retune sequencer: a new change restarts the settle window
	always_comb begin
		rt_d = rt_q;
		rt_cnt_d = rt_cnt_q;
		unique case (rt_q)
			LCSC_RT_IDLE: begin
				if (clk_fields_change) begin
					rt_d = LCSC_RT_BUSY;
					rt_cnt_d = LCSC_RETUNE_W'(RETUNE_CYCLES - 1);
				end
			end
			LCSC_RT_BUSY: begin
				if (clk_fields_change) begin
					rt_cnt_d = LCSC_RETUNE_W'(RETUNE_CYCLES - 1);
				end else if (rt_cnt_q == '0) begin
					rt_d = LCSC_RT_IDLE;
				end else begin
					rt_cnt_d = rt_cnt_q - 1'b1;
				end
			end
			default: begin
				rt_d = LCSC_RT_IDLE;
				rt_cnt_d = '0;
			end
		endcase
	end

	// Synthesizer registers
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ref_khz_q <= LCSC_KHZ_E1;
			out_khz_q <= LCSC_KHZ_E1;
			rt_q <= LCSC_RT_IDLE;
			rt_cnt_q <= '0;
		end else begin
			ref_khz_q <= ref_khz_d;
			out_khz_q <= out_khz_d;
			rt_q <= rt_d;
			rt_cnt_q <= rt_cnt_d;
		end
	end

	// ****************************************************************
	// Shared indicator and channel logic
	// ****************************************************************
	logic [CHANNELS-1:0] ind_q, ind_d;
	logic [LCSC_LOS_W-1:0] los_thr;

	// Threshold and indicator source are global to all channels
	always_comb begin
		if (ctrl_q[LCSC_BIT_EXT_LOS]) begin
			los_thr = LCSC_LOS_EXT_ZEROS;
		end else if (ctrl_q[LCSC_BIT_RATE]) begin
			los_thr = LCSC_LOS_T1_ZEROS;
		end else begin
			los_thr = LCSC_LOS_E1_ZEROS;
		end
		ind_d = ctrl_q[LCSC_BIT_VIOL_OVF_SEL] ? counter_overflow_in : line_code_violation_in;
	end

	// Indicator register
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ind_q <= '0;
		end else begin
			ind_q <= ind_d;
		end
	end

	// One channel instance per line
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		lcsc_los_chan u_chan (
			.clock_in(clock_in),
			.rst_n_in(rst_n_in),
			.bit_valid_in(rx_bit_valid_in[ch]),
			.bit_mark_in(rx_bit_mark_in[ch]),
			.rx_pos_in(rx_pos_in[ch]),
			.rx_neg_in(rx_neg_in[ch]),
			.threshold_in(los_thr),
			.mute_en_in(ctrl_q[LCSC_BIT_MUTE]),
			.los_out(receive_loss_of_signal_out[ch]),
			.rx_pos_out(receive_positive_data_out[ch]),
			.rx_neg_out(receive_negative_violation_out[ch])
		);
	end

	// ****************************************************************
	// Outputs, all from flip-flops
	// ****************************************************************
	assign host_rdata_out = rdata_q;
	assign violation_overflow_indicator_out = ind_q;
	assign synth_ref_select_field_out = ctrl_q[LCSC_BIT_REF_SEL_HI:LCSC_BIT_REF_SEL_LO];
	assign master_rate_select_out = ctrl_q[LCSC_BIT_RATE];
	assign synth_ref_khz_out = ref_khz_q;
	assign synth_clock_output_khz_out = out_khz_q;
	assign synth_retune_busy_out = rt_q[1];
	assign in_circuit_test_hiz_out = ctrl_q[LCSC_BIT_HIZ];

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	chk_write_lands: assert property (
		host_wr_in && hits_ctrl(host_addr_in) |=> ctrl_q == $past(host_wdata_in))
		else $error("control write not stored");
	chk_read_back: assert property (
		host_rd_in && hits_ctrl(host_addr_in) && !host_wr_in |=> host_rdata_out == ctrl_q)
		else $error("read data differs from control register");
	chk_ind_source: assert property (
		1'b1 |=> violation_overflow_indicator_out == ($past(ctrl_q[LCSC_BIT_VIOL_OVF_SEL])
			? $past(counter_overflow_in) : $past(line_code_violation_in)))
		else $error("indicator follows wrong source");
	chk_ref_freq: assert property (
		ctrl_q[LCSC_BIT_REF_SEL_HI:LCSC_BIT_REF_SEL_LO] == LCSC_REF_SEL_T1 && $stable(ctrl_q)
		|-> synth_ref_khz_out == LCSC_KHZ_T1)
		else $error("reference frequency not 1544 kHz for code 001");
	chk_out_rate: assert property (
		$stable(ctrl_q) |-> synth_clock_output_khz_out == (ctrl_q[LCSC_BIT_RATE] ? LCSC_KHZ_T1 : LCSC_KHZ_E1))
		else $error("synthesizer rate does not match rate bit");
	chk_retune_start: assert property (
		$changed(ctrl_q[LCSC_BIT_REF_SEL_HI:LCSC_UPPER_LO]) |-> synth_retune_busy_out)
		else $error("retune not flagged after clock field change");
	chk_retune_hold: assert property (
		$rose(synth_retune_busy_out) |-> synth_retune_busy_out [*8])
		else $error("retune window ended early");
	chk_lower_quiet: assert property (
		$changed(ctrl_q[LCSC_BIT_MUTE:LCSC_BIT_HIZ]) && !$changed(ctrl_q[LCSC_BIT_REF_SEL_HI:LCSC_UPPER_LO])
		|-> !$rose(synth_retune_busy_out))
		else $error("lower group write started a retune");
	chk_thr_select: assert property (
		ctrl_q[LCSC_BIT_EXT_LOS] |-> los_thr == LCSC_LOS_EXT_ZEROS)
		else $error("extended threshold not applied");
	cov_retune: cover property ($rose(synth_retune_busy_out) ##[1:1000] $fell(synth_retune_busy_out));
	cov_overflow_src: cover property (ctrl_q[LCSC_BIT_VIOL_OVF_SEL] && |counter_overflow_in);
	cov_mute_los: cover property (ctrl_q[LCSC_BIT_MUTE] && |receive_loss_of_signal_out);
endmodule

// ---- verification/lcsc_host_model.sv ----
// Host microprocessor model driving the clock select register port
`timescale 1ns/10ps
module lcsc_host_model (
	// Clock
	input wire logic clock_in,
	// Register strobes
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	// Last value the host believes is in the register
	logic [7:0] shadow_q;

	// Idle bus at time zero
	initial begin
		shadow_q = 8'h00;
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// One strobe cycle, launched and released at falling edges
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(negedge clock_in);
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(negedge clock_in);
		wr_out = 1'b0;
		rd_out = 1'b0;
	endtask

	// ****************************************************************
	// Control register update
	// ****************************************************************
	// One group per write
	// Upper group goes first, so the retune never sees a lower bit move with it
	task automatic update(input logic [7:0] v);
		logic [7:0] mid;
		mid = {v[7:3], shadow_q[2:0]};
		if (mid != shadow_q && mid != v) begin
			access(8'h81, mid, 1'b1);
		end
		access(8'h81, v, 1'b1);
		shadow_q = v;
	endtask
endmodule

// ---- verification/lcsc_top_test.sv ----
// Self-checking testbench of the clock select and receive control block
`timescale 1ns/10ps
module lcsc_top_test;
	import lcsc_pkg::*;
	logic clock_in;
	logic rst_n_in;
	logic [7:0] addr, wdata, rdata, line_code_violation, ovf, valid, mark, pos, neg;
	logic wr, rd, rate, busy, hiz;
	logic [7:0] ind, los, pos_o, neg_o;
	logic [2:0] sel;
	logic [11:0] ref_khz, clk_khz;
	int mismatches = 0;
	int compares = 0;

	// ****************************************************************
	// Design, host and clock
	// ****************************************************************
	lcsc_top #(.RETUNE_CYCLES(8)) i_lcsc_top (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.host_addr_in(addr), .host_wdata_in(wdata), .host_wr_in(wr), .host_rd_in(rd),
		.host_rdata_out(rdata), .line_code_violation_in(line_code_violation), .counter_overflow_in(ovf),
		.rx_bit_valid_in(valid), .rx_bit_mark_in(mark), .rx_pos_in(pos), .rx_neg_in(neg),
		.violation_overflow_indicator_out(ind), .receive_loss_of_signal_out(los),
		.receive_positive_data_out(pos_o), .receive_negative_violation_out(neg_o),
		.synth_ref_select_field_out(sel), .master_rate_select_out(rate), .synth_ref_khz_out(ref_khz),
		.synth_clock_output_khz_out(clk_khz), .synth_retune_busy_out(busy), .in_circuit_test_hiz_out(hiz));
	lcsc_host_model i_lcsc_host_model (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));

	// 40 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Case equality so an unknown never matches
	task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	// Feed n valid bits on every channel, then settle two cycles
	task automatic bits(input int n, input logic one);
		valid = 8'hFF;
		mark = {8{one}};
		idle(n);
		valid = 8'h00;
		idle(2);
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog, well beyond the roughly 4500 cycles of the tests
	initial begin
		repeat (20000) @(posedge clock_in);
		mismatches++;
		complete_run();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{rst_n_in, line_code_violation, ovf, valid, mark} = '0;
		pos = 8'h3C;
		neg = 8'hC3;
		idle(10);
		rst_n_in = 1'b1;
		i_lcsc_host_model.access(8'h81, 8'h00, 1'b0);
		check_val(rdata, LCSC_CTRL_RESET);
		check_val(clk_khz, LCSC_KHZ_E1);
		i_lcsc_host_model.access(8'h82, 8'hFF, 1'b1);
		i_lcsc_host_model.access(8'h40, 8'h00, 1'b0);
		check_val(rdata, 8'h00);
		i_lcsc_host_model.access(8'h81, 8'h00, 1'b0);
		check_val(rdata, 8'h00);
		end_test("reset");
		i_lcsc_host_model.update(8'h08);
		check_val(clk_khz, LCSC_KHZ_T1);
		check_val(rate, 1'b1);
		check_val(busy, 1'b1);
		idle(12);
		check_val(busy, 1'b0);
		i_lcsc_host_model.update(8'h18);
		check_val(ref_khz, LCSC_KHZ_T1);
		check_val(sel, 3'h1);
		i_lcsc_host_model.access(LCSC_ADDR_CTRL, 8'h00, 1'b0);
		check_val(rdata, 8'h18);
		i_lcsc_host_model.update(8'h00);
		check_val(ref_khz, LCSC_KHZ_E1);
		check_val(clk_khz, LCSC_KHZ_E1);
		check_val(rate, 1'b0);
		// Let the settle window of the last clock change run out first
		idle(12);
		i_lcsc_host_model.update(8'h03);
		check_val(busy, 1'b0);
		check_val(hiz, 1'b1);
		i_lcsc_host_model.update(8'h00);
		end_test("clock");
		// Opposite patterns on the two sources so every bit toggles
		line_code_violation = 8'h5A;
		ovf = 8'hA5;
		idle(1);
		check_val(ind, 8'h5A);
		i_lcsc_host_model.update(8'h80);
		// Source select acts from the register, one cycle after the write
		idle(1);
		check_val(ind, 8'hA5);
		line_code_violation = 8'hA5;
		ovf = 8'h5A;
		idle(1);
		check_val(ind, 8'h5A);
		i_lcsc_host_model.update(8'h00);
		idle(1);
		check_val(ind, 8'hA5);
		{line_code_violation, ovf} = '0;
		end_test("indicator");
		bits(31, 1'b0);
		check_val(los, 8'h00);
		bits(1, 1'b0);
		check_val(los, 8'hFF);
		check_val(pos_o, 8'h3C);
		i_lcsc_host_model.update(8'h04);
		idle(2);
		check_val(pos_o, 8'h00);
		check_val(neg_o, 8'h00);
		bits(1, 1'b1);
		check_val(los, 8'h00);
		check_val(neg_o, 8'hC3);
		// Swap the data patterns so every data bit is seen passing both ways
		pos = 8'hC3;
		neg = 8'h3C;
		idle(2);
		check_val(pos_o, 8'hC3);
		check_val(neg_o, 8'h3C);
		end_test("e1 los and mute");
		i_lcsc_host_model.update(8'h08);
		bits(249, 1'b0);
		check_val(los, 8'h00);
		bits(1, 1'b0);
		check_val(los, 8'hFF);
		bits(1, 1'b1);
		i_lcsc_host_model.update(8'h0A);
		bits(4095, 1'b0);
		check_val(los, 8'h00);
		bits(1, 1'b0);
		check_val(los, 8'hFF);
		end_test("t1 and extended los");
		complete_run();
	end
endmodule
